/* File: rtl/ptpe_engine.v */
// pulse timing engine: settings, limit checks, output enables and pulse generation
// Behaviour
// - duty percent accepted only 1..99; min keyword gives 1, max gives 99.
// - after defaulting, duty mode off and duty value fifty.
// - duty mode and external trigger mode never active together.
// - period under 5 ns: width limit half period, or minus 0.5 ns below 1 ns.
// - period 5 to 10 ns: width limit 0.7 period minus 1 ns.
// - period 10 ns up: width limit 0.9 period minus 3 ns.
// - double pulse: width limit 0.8 spacing minus 1.1 or 0.6 ns.
// - delay accepted from zero to 99.9 ms, default zero.
// - main pulse follows cycle marker by fixed 20 ns plus delay.
// - delay limited by period in three bands.
// - one selector picks delay (off) or double pulse (on); no delay in double.
// - true and inverted outputs enabled separately, both disabled by default.
// - driver off while an output switches between enabled and disabled.
// - both outputs disabled at power-on, reset command, recall 0, overvoltage.
// - burst mode refused while period below 5 ns.
// - double pulse forbidden below 5 ns; spacing limited by period bands.
// - double pulse: width limited against period minus spacing in three bands.
// - width accepted 0.5 ns to 99.9 ms, default 100 us.
// - double selector reads back as off or on.
// - duty setting reads back as plain integer.
`timescale 1ns/10ps
`default_nettype none
`include "ptpe_regs.vh"
module ptpe_engine
(
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire overvoltage,
    output reg cycle_marker_output,
    output reg pulse_output,
    output reg inverted_pulse_output,
    output reg pulse_driver_on,
    output reg inverted_driver_on
);

////////////////////////////////////////////////////////////////////////
// settings

reg [35:0] period;
reg [35:0] width_set;
reg [35:0] first_pulse_delay;
reg [35:0] double_pulse_spacing;
reg [6:0] duty_cycle_setting;
reg duty_mode;
reg double_mode;
reg external_trigger_mode;
reg burst_mode;
reg out_en;
reg inv_en;
reg conflict;
reg refused;
reg ov_s1;
reg ov_s2;
reg [7:0] out_sw_cnt;
reg [7:0] inv_sw_cnt;

wire wr = psel & penable & pwrite & clk_en;
wire [35:0] wdat = {4'h0, pwdata};
assign pready = 1'b1;
assign pslverr = 1'b0;

////////////////////////////////////////////////////////////////////////
// limit functions, all in 10 ps units

function [35:0] width_lim;
    input [35:0] p;
    input [35:0] w;
    reg [39:0] t;
    begin
        t = 40'h0;
        if (p < `PTPE_T_5NS)
        begin
            t = {4'h0, p} >> 1;
            if (w < `PTPE_T_1NS)
                t = t - `PTPE_T_0P50NS;
        end
        else if (p < `PTPE_T_10NS)
            t = ({4'h0, p} * 40'd7) / 40'd10 - `PTPE_T_1NS;
        else
            t = ({4'h0, p} * 40'd9) / 40'd10 - `PTPE_T_3NS;
        width_lim = t[35:0];
    end
endfunction

function [35:0] delay_lim;
    input [35:0] p;
    reg [39:0] t;
    begin
        if (p < `PTPE_T_5NS)
            t = ({4'h0, p} >> 1) - `PTPE_T_1NS;
        else if (p < `PTPE_T_10NS)
            t = ({4'h0, p} * 40'd7) / 40'd10 - `PTPE_T_2NS;
        else
            t = ({4'h0, p} * 40'd9) / 40'd10 - `PTPE_T_4NS;
        delay_lim = t[35:0];
    end
endfunction

// full check of one candidate setting; 1 means legal
function check_ok;
    input [35:0] p;
    input [35:0] w;
    input [35:0] d;
    input [35:0] s;
    input dbl;
    reg [39:0] pd;
    reg [39:0] lw;
    reg ok;
    begin
        ok = (w >= `PTPE_T_0P50NS) && (w <= `PTPE_T_MAX) && (p <= `PTPE_T_MAX);
        if (w > width_lim(p, w))
            ok = 1'b0;
        if ((p < `PTPE_T_5NS) && (w >= `PTPE_T_1NS) && (w > (p >> 1)))
            ok = 1'b0;
        if (!dbl && ((d > `PTPE_T_MAX) || (d > delay_lim(p)) || (delay_lim(p) > p)))
            ok = ok && (d == 36'h0);
        if (dbl)
        begin
            if (p < `PTPE_T_5NS)
                ok = 1'b0;
            else if (p < `PTPE_T_10NS)
            begin
                if (s > (p >> 1))
                    ok = 1'b0;
            end
            else if ({4'h0, s} > ({4'h0, p} * 40'd9) / 40'd10 - `PTPE_T_4NS)
                ok = 1'b0;
            if (w < `PTPE_T_1NS)
                lw = ({4'h0, s} * 40'd8) / 40'd10 - `PTPE_T_1P10NS;
            else
                lw = ({4'h0, s} * 40'd8) / 40'd10 - `PTPE_T_0P60NS;
            if (s < `PTPE_T_2NS || {4'h0, w} > lw)
                ok = 1'b0;
            pd = (p > s) ? {4'h0, p - s} : 40'h0;
            if (w < `PTPE_T_1NS)
                lw = (pd * 40'd7) / 40'd10 - `PTPE_T_1P50NS;
            else if (w < `PTPE_T_10NS)
                lw = (pd * 40'd7) / 40'd10 - `PTPE_T_1NS;
            else
                lw = (pd * 40'd85) / 40'd100 - `PTPE_T_2P50NS;
            if (pd == 40'h0 || {4'h0, w} > lw)
                ok = 1'b0;
        end
        check_ok = ok;
    end
endfunction

function [35:0] duty_width;
    input [35:0] p;
    input [6:0] dc;
    input dbl;
    reg [47:0] t;
    begin
        t = {12'h0, p} * {41'h0, dc};
        if (dbl)
            t = t / 48'd200;
        else
            t = t / 48'd100;
        duty_width = t[35:0];
    end
endfunction

////////////////////////////////////////////////////////////////////////
// candidate settings for the write in progress

reg [35:0] c_per;
reg [35:0] c_wid;
reg [35:0] c_del;
reg [35:0] c_spc;
reg [6:0] c_duty;
reg c_dmode;
reg c_dbl;
reg c_ok;
reg [7:0] duty_key;

always @*
begin
    c_per = period;
    c_wid = width_set;
    c_del = first_pulse_delay;
    c_spc = double_pulse_spacing;
    c_duty = duty_cycle_setting;
    c_dmode = duty_mode;
    c_dbl = double_mode;
    duty_key = pwdata[7:0];
    c_ok = 1'b1;
    if (wr)
    begin
        case (paddr)
            `PTPE_PERIOD_ADDR: c_per = wdat;
            `PTPE_WIDTH_ADDR: c_wid = wdat;
            `PTPE_DELAY_ADDR: c_del = wdat;
            `PTPE_SPACING_ADDR: c_spc = wdat;
            `PTPE_MODE_ADDR: c_dbl = pwdata[0];
            `PTPE_CTRL_ADDR:
            begin
                c_dmode = pwdata[`PTPE_CTRL_DUTY_MODE];
                c_dbl = pwdata[`PTPE_CTRL_DOUBLE];
            end
            `PTPE_DUTY_ADDR:
            begin
                if (duty_key == `PTPE_DUTY_KEY_MIN)
                    c_duty = `PTPE_DUTY_MIN;
                else if (duty_key == `PTPE_DUTY_KEY_MAX)
                    c_duty = `PTPE_DUTY_MAX;
                else if (pwdata >= 32'd1 && pwdata <= 32'd99)
                    c_duty = pwdata[6:0];
                else
                    c_ok = 1'b0;
            end
            default: c_dbl = double_mode;
        endcase
    end
    if (c_dmode)
        c_wid = duty_width(c_per, c_duty, c_dbl);
    c_ok = c_ok && check_ok(c_per, c_wid, c_dbl ? 36'h0 : c_del, c_spc, c_dbl);
end

////////////////////////////////////////////////////////////////////////
// register writes

wire cmd_wr = wr && (paddr == `PTPE_CMD_ADDR);
wire defaulting = cmd_wr && (pwdata[`PTPE_CMD_RESET] || pwdata[`PTPE_CMD_RECALL0]);
wire ov_event = ov_s2;
wire [31:0] ctrl_w = pwdata;
wire dc_external_trigger_mode_clash = ctrl_w[`PTPE_CTRL_DUTY_MODE] && ctrl_w[`PTPE_CTRL_EXTERNAL_TRIGGER_MODE_MODE];
wire burst_bad = ctrl_w[`PTPE_CTRL_BURST] && (period < `PTPE_T_5NS);
wire ctrl_wr = wr && (paddr == `PTPE_CTRL_ADDR);
wire set_wr = wr && (paddr != `PTPE_CMD_ADDR) && (paddr != `PTPE_STATUS_ADDR) && !ctrl_wr;

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        period <= `PTPE_PERIOD_RST;
        width_set <= `PTPE_WIDTH_RST;
        first_pulse_delay <= 36'h0;
        double_pulse_spacing <= 36'h0;
        duty_cycle_setting <= `PTPE_DUTY_RST;
        duty_mode <= 1'b0;
        double_mode <= 1'b0;
        external_trigger_mode <= 1'b0;
        burst_mode <= 1'b0;
        out_en <= 1'b0;
        inv_en <= 1'b0;
        conflict <= 1'b0;
        refused <= 1'b0;
        ov_s1 <= 1'b0;
        ov_s2 <= 1'b0;
    end
    else if (clk_en)
    begin
        ov_s1 <= overvoltage;
        ov_s2 <= ov_s1;
        if (defaulting)
        begin
            period <= `PTPE_PERIOD_RST;
            width_set <= `PTPE_WIDTH_RST;
            first_pulse_delay <= 36'h0;
            double_pulse_spacing <= 36'h0;
            duty_cycle_setting <= `PTPE_DUTY_RST;
            duty_mode <= 1'b0;
            double_mode <= 1'b0;
            external_trigger_mode <= 1'b0;
            burst_mode <= 1'b0;
            out_en <= 1'b0;
            inv_en <= 1'b0;
        end
        else if (ctrl_wr)
        begin
            // a clash or refused burst keeps the old control word whole
            if (dc_external_trigger_mode_clash || burst_bad || !c_ok)
                refused <= 1'b1;
            else
            begin
                duty_mode <= c_dmode;
                double_mode <= c_dbl;
                width_set <= c_wid;
                external_trigger_mode <= ctrl_w[`PTPE_CTRL_EXTERNAL_TRIGGER_MODE_MODE];
                burst_mode <= ctrl_w[`PTPE_CTRL_BURST];
                out_en <= ctrl_w[`PTPE_CTRL_OUT_EN] & ~ov_event;
                inv_en <= ctrl_w[`PTPE_CTRL_INV_EN] & ~ov_event;
            end
        end
        else if (set_wr)
        begin
            if (c_ok)
            begin
                period <= c_per;
                width_set <= c_wid;
                first_pulse_delay <= c_del;
                double_pulse_spacing <= c_spc;
                duty_cycle_setting <= c_duty;
                double_mode <= c_dbl;
            end
            else
                conflict <= 1'b1;
        end
        if (ov_event)
        begin
            out_en <= 1'b0;
            inv_en <= 1'b0;
        end
        // a new conflict in the same cycle beats the clear
        if (cmd_wr && pwdata[`PTPE_CMD_CLR_CONFLICT] && !(set_wr && !c_ok))
        begin
            conflict <= 1'b0;
            refused <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// read mux; duty and double selector read back as plain values

always @*
begin
    prdata = 32'h0;
    case (paddr)
        `PTPE_CTRL_ADDR: prdata = {26'h0, inv_en, out_en, burst_mode, external_trigger_mode, double_mode, duty_mode};
        `PTPE_PERIOD_ADDR: prdata = period[31:0];
        `PTPE_WIDTH_ADDR: prdata = width_set[31:0];
        `PTPE_DELAY_ADDR: prdata = first_pulse_delay[31:0];
        `PTPE_SPACING_ADDR: prdata = double_pulse_spacing[31:0];
        `PTPE_DUTY_ADDR: prdata = {25'h0, duty_cycle_setting};
        `PTPE_MODE_ADDR: prdata = {31'h0, double_mode};
        `PTPE_STATUS_ADDR: prdata = {27'h0, (inv_sw_cnt != 8'h0), (out_sw_cnt != 8'h0), ov_s2, refused, conflict};
        default: prdata = 32'h0;
    endcase
end

////////////////////////////////////////////////////////////////////////
// pulse generation in 5 ns cycles

wire [35:0] per_cyc = (period + `PTPE_UNITS_PER_CYCLE - 36'd1) / `PTPE_UNITS_PER_CYCLE;
wire [35:0] wid_cyc = width_set / `PTPE_UNITS_PER_CYCLE;
wire [35:0] spc_cyc = double_pulse_spacing / `PTPE_UNITS_PER_CYCLE;
wire [35:0] del_cyc = double_mode ? 36'h0 : first_pulse_delay / `PTPE_UNITS_PER_CYCLE;
wire [35:0] start_cyc = del_cyc + `PTPE_FIXED_DELAY_CYC;
reg [35:0] ph;
reg pulse_raw;
reg prev_out_en;
reg prev_inv_en;

always @*
begin
    pulse_raw = (ph >= start_cyc) && (ph < start_cyc + wid_cyc);
    if (double_mode && (ph >= start_cyc + spc_cyc) && (ph < start_cyc + spc_cyc + wid_cyc))
        pulse_raw = 1'b1;
end

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        ph <= 36'h0;
        cycle_marker_output <= 1'b0;
        pulse_output <= 1'b0;
        inverted_pulse_output <= 1'b0;
        pulse_driver_on <= 1'b0;
        inverted_driver_on <= 1'b0;
        prev_out_en <= 1'b0;
        prev_inv_en <= 1'b0;
        out_sw_cnt <= 8'h0;
        inv_sw_cnt <= 8'h0;
    end
    else if (clk_en)
    begin
        // phase counter runs start_cyc past the period so the delayed pulse is not cut short
        ph <= (ph + 36'd1 >= per_cyc + start_cyc) ? 36'h0 : ph + 36'd1;
        cycle_marker_output <= (ph == 36'h0);
        prev_out_en <= out_en;
        prev_inv_en <= inv_en;
        if (out_en != prev_out_en)
            out_sw_cnt <= `PTPE_SWITCH_CYC;
        else if (out_sw_cnt != 8'h0)
            out_sw_cnt <= out_sw_cnt - 8'h1;
        if (inv_en != prev_inv_en)
            inv_sw_cnt <= `PTPE_SWITCH_CYC;
        else if (inv_sw_cnt != 8'h0)
            inv_sw_cnt <= inv_sw_cnt - 8'h1;
        pulse_driver_on <= out_en && (out_en == prev_out_en) && (out_sw_cnt == 8'h0);
        inverted_driver_on <= inv_en && (inv_en == prev_inv_en) && (inv_sw_cnt == 8'h0);
        pulse_output <= out_en & pulse_raw;
        inverted_pulse_output <= inv_en & ~pulse_raw;
    end
end

endmodule // ptpe_engine
`default_nettype wire

/* File: rtl/ptpe_regs.vh */
// register map, field positions, reset values and timing counts of the pulse timing engine
`ifndef PTPE_REGS_VH
`define PTPE_REGS_VH
`define PTPE_CTRL_ADDR 12'h000
`define PTPE_PERIOD_ADDR 12'h004
`define PTPE_WIDTH_ADDR 12'h008
`define PTPE_DELAY_ADDR 12'h00C
`define PTPE_SPACING_ADDR 12'h010
`define PTPE_DUTY_ADDR 12'h014
`define PTPE_STATUS_ADDR 12'h018
`define PTPE_CMD_ADDR 12'h01C
`define PTPE_MODE_ADDR 12'h020
// control bits
`define PTPE_CTRL_DUTY_MODE 0
`define PTPE_CTRL_DOUBLE 1
`define PTPE_CTRL_EXTERNAL_TRIGGER_MODE_MODE 2
`define PTPE_CTRL_BURST 3
`define PTPE_CTRL_OUT_EN 4
`define PTPE_CTRL_INV_EN 5
// command bits (write-one pulses)
`define PTPE_CMD_RESET 0
`define PTPE_CMD_RECALL0 1
`define PTPE_CMD_CLR_CONFLICT 2
// status bits
`define PTPE_ST_CONFLICT 0
`define PTPE_ST_REFUSED 1
`define PTPE_ST_OVERVOLT 2
`define PTPE_ST_OUT_BUSY 3
`define PTPE_ST_INV_BUSY 4
// times are held in units of 10 ps
`define PTPE_T_0P50NS 32'd50
`define PTPE_T_0P60NS 32'd60
`define PTPE_T_1NS 32'd100
`define PTPE_T_1P10NS 32'd110
`define PTPE_T_1P50NS 32'd150
`define PTPE_T_2NS 32'd200
`define PTPE_T_2P50NS 32'd250
`define PTPE_T_3NS 32'd300
`define PTPE_T_4NS 32'd400
`define PTPE_T_5NS 32'd500
`define PTPE_T_10NS 32'd1000
`define PTPE_T_MAX 36'd9990000000
// default period of 1 ms keeps the 100 us default width inside its limit
`define PTPE_PERIOD_RST 36'd100000000
`define PTPE_WIDTH_RST 36'd10000000
`define PTPE_DUTY_RST 7'd50
`define PTPE_DUTY_MIN 7'd1
`define PTPE_DUTY_MAX 7'd99
`define PTPE_DUTY_KEY_MIN 8'hFE
`define PTPE_DUTY_KEY_MAX 8'hFF
// time units per clock cycle (5 ns at 200 MHz)
`define PTPE_UNITS_PER_CYCLE 32'd500
`define PTPE_FIXED_DELAY_NS 20
`define PTPE_FIXED_DELAY_CYC (`PTPE_FIXED_DELAY_NS / 5)
`define PTPE_SWITCH_CYC 8'd4
`endif

/* File: sim/ptpe_engine_sva.sv */
// concurrent checks on the pulse timing engine ports
`timescale 1ns/10ps
`default_nettype none
`include "ptpe_regs.vh"
module ptpe_engine_sva
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic overvoltage,
    input wire logic cycle_marker_output,
    input wire logic pulse_output,
    input wire logic inverted_pulse_output,
    input wire logic pulse_driver_on,
    input wire logic inverted_driver_on
);
    wire wr_acc;
    logic del_zero;
    assign wr_acc = psel && penable && pwrite && clk_en;
    // shadow of a zero delay; a refused write only silences the latency check
    always @(posedge pclk or negedge presetn)
        if (!presetn)
            del_zero <= 1'b1;
        else if (wr_acc && paddr == `PTPE_DELAY_ADDR)
            del_zero <= (pwdata == 32'h0);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_ctrl_wr;
        wr_acc && paddr == `PTPE_CTRL_ADDR && pwdata[3:0] == 4'h0;
    endsequence
    sequence s_rd(logic [11:0] a);
        psel && penable && !pwrite && paddr == a;
    endsequence
    AST_RST_DRV: assert property ($rose(presetn) |-> !pulse_driver_on && !inverted_driver_on)
        else $error("driver on after reset");
    AST_OV_DRV: assert property (overvoltage [*5] |-> !pulse_driver_on && !inverted_driver_on)
        else $error("driver on during overvoltage");
    AST_DIS_BOTH: assert property (s_ctrl_wr ##0 !pwdata[4] && !pwdata[5] |->
        ##2 !pulse_driver_on && !inverted_driver_on && !inverted_pulse_output) else $error("disable ignored");
    AST_EN_GAP: assert property (s_ctrl_wr ##0 pwdata[4] && !pulse_driver_on |=>
        !pulse_driver_on [*3] ##[1:8] pulse_driver_on) else $error("enable switch window wrong");
    AST_INV_GAP: assert property ($rose(inverted_driver_on) |-> !$past(inverted_driver_on, 4))
        else $error("inverted driver on too soon");
    AST_FIX_DLY: assert property ($rose(cycle_marker_output) && del_zero && pulse_driver_on |->
        ##4 $rose(pulse_output)) else $error("fixed delay wrong");
    AST_INV_CMP: assert property (inverted_driver_on |-> inverted_pulse_output == !pulse_output)
        else $error("inverted output not complement");
    AST_DUTY_RD: assert property (s_rd(`PTPE_DUTY_ADDR) |-> prdata >= 32'h1 && prdata <= 32'h63)
        else $error("duty read out of range");
    AST_MODE_RD: assert property (s_rd(`PTPE_MODE_ADDR) |-> prdata[31:1] == 31'h0)
        else $error("selector read not off or on");
endmodule // ptpe_engine_sva
bind ptpe_engine ptpe_engine_sva u_sva
(
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .overvoltage(overvoltage), .cycle_marker_output(cycle_marker_output), .pulse_output(pulse_output),
    .inverted_pulse_output(inverted_pulse_output), .pulse_driver_on(pulse_driver_on),
    .inverted_driver_on(inverted_driver_on)
);
`default_nettype wire

/* File: sim/ptpe_load_model.sv */
// load model at the true pulse output: marker-to-pulse latency and pulse length
`timescale 1ns/10ps
`default_nettype none
module ptpe_load_model
(
    input wire logic pclk,
    input wire logic marker,
    input wire logic pulse,
    input wire logic drv_on,
    output logic [31:0] lat,
    output logic [31:0] wid
);
    logic [31:0] cnt = 32'h0;
    logic [31:0] hi = 32'h0;
    logic prev = 1'b0;
    // a load sees edges only while the driver is on
    always @(posedge pclk)
    begin
        prev <= pulse;
        cnt <= marker ? 32'h1 : cnt + 32'h1;
        hi <= pulse ? hi + 32'h1 : 32'h0;
        if (drv_on && pulse && !prev)
            lat <= cnt;
        if (drv_on && !pulse && prev)
            wid <= hi;
    end
endmodule // ptpe_load_model
`default_nettype wire

/* File: sim/tb_pulse_timing_parameter_engine.sv */
// bench: apb register checks, limits, enables and pulse timing of the engine
`timescale 1ns/10ps
`default_nettype none
`include "ptpe_regs.vh"
module tb_pulse_timing_parameter_engine;
    localparam [11:0] CT = `PTPE_CTRL_ADDR;
    localparam [11:0] PE = `PTPE_PERIOD_ADDR;
    localparam [11:0] WI = `PTPE_WIDTH_ADDR;
    localparam [11:0] DE = `PTPE_DELAY_ADDR;
    localparam [11:0] SP = `PTPE_SPACING_ADDR;
    localparam [11:0] DU = `PTPE_DUTY_ADDR;
    localparam [11:0] ST = `PTPE_STATUS_ADDR;
    localparam [11:0] CM = `PTPE_CMD_ADDR;
    localparam [11:0] MO = `PTPE_MODE_ADDR;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic ovr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, lat, wid, r;
    logic pready, pslverr, mk, pu, iv, drv, idrv;
    int failures = 0;
    int n_checks = 0;
    int cycles = 0;
    logic [31:0] exp_q[$], msk_q[$];
    logic [11:0] adr_q[$];
    logic [31:0] p[4] = '{32'hC8, 32'h190, 32'h320, 32'h7D0};
    logic [31:0] wl[4] = '{32'h32, 32'hC8, 32'h1CC, 32'h5DC};
    logic [31:0] dl[4] = '{32'h0, 32'h64, 32'h168, 32'h578};
    ptpe_engine uut
    (
        .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .overvoltage(ovr), .cycle_marker_output(mk), .pulse_output(pu), .inverted_pulse_output(iv),
        .pulse_driver_on(drv), .inverted_driver_on(idrv)
    );
    ptpe_load_model load
    (
        .pclk(pclk), .marker(mk), .pulse(pu), .drv_on(drv), .lat(lat), .wid(wid)
    );
    initial
    begin
        forever #2.5 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (s !== e)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF);
        adr_q.push_back(a);
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        apb(1'b0, a, 32'h0);
    endtask
    // first pulse after a marker, so a double pulse never hides the first one
    task automatic meas(input logic [31:0] e);
        @(posedge mk);
        @(posedge pu);
        repeat (2) @(posedge pclk);
        chk("latency", e, lat);
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    always @(posedge pclk)
        if (psel && penable && pready && !pwrite && adr_q.size() > 0)
            chk($sformatf("reg %h", adr_q.pop_front()), exp_q.pop_front(), prdata & msk_q.pop_front());
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            stop_test();
        end
    end
    ////////////////////////////////////////////////////////////////
    initial
    begin
        r = $urandom(32'h79bf9d88);
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(CT, 32'h0, 32'h3F);
        rd(WI, 32'h989680);
        rd(DE, 32'h0);
        rd(DU, 32'h32);
        rd(MO, 32'h0);
        rd(12'h040, 32'h0);
        $display("test defaults done");
        wr(DU, 32'h0);
        rd(ST, 32'h1, 32'h1);
        wr(DU, 32'h64);
        rd(DU, 32'h32);
        wr(CM, 32'h4);
        rd(ST, 32'h0, 32'h3);
        wr(DU, 32'hFE);
        rd(DU, 32'h1);
        wr(DU, 32'hFF);
        rd(DU, 32'h63);
        r = $urandom_range(99, 1);
        wr(DU, r);
        rd(DU, r);
        $display("test duty range done");
        wr(WI, 32'h32);
        wr(PE, 32'h186A0);
        wr(DU, 32'h19);
        wr(CT, 32'h1);
        rd(WI, 32'h61A8);
        wr(SP, 32'h9C40);
        wr(MO, 32'h1);
        rd(WI, 32'h30D4);
        rd(MO, 32'h1);
        wr(PE, 32'h30D40);
        rd(WI, 32'h61A8);
        wr(CT, 32'h5);
        rd(CT, 32'h1, 32'h5);
        rd(ST, 32'h2, 32'h2);
        wr(MO, 32'h0);
        rd(WI, 32'hC350);
        wr(CT, 32'h0);
        wr(SP, 32'h0);
        wr(WI, 32'h32);
        wr(CM, 32'h4);
        $display("test duty mode done");
        for (int i = 0; i < 4; i++)
        begin
            wr(PE, p[i]);
            wr(WI, wl[i]);
            wr(WI, wl[i] + 32'h1);
            rd(WI, wl[i]);
            wr(DE, dl[i]);
            wr(DE, dl[i] + 32'h1);
            rd(DE, dl[i]);
            rd(ST, 32'h1, 32'h1);
            wr(DE, 32'h0);
            wr(WI, 32'h32);
            wr(CT, 32'h8);
            rd(CT, (p[i] >= 32'h1F4) ? 32'h8 : 32'h0, 32'h8);
            wr(CT, 32'h0);
            if (p[i] < 32'h1F4)
            begin
                wr(MO, 32'h1);
                rd(MO, 32'h0);
            end
            wr(CM, 32'h4);
        end
        wr(WI, 32'h31);
        rd(WI, 32'h32);
        $display("test limits done");
        wr(PE, 32'h186A0);
        wr(WI, 32'h2710);
        wr(CT, 32'h10);
        rd(ST, 32'h8, 32'h18);
        wait (drv === 1'b1);
        meas(32'h4);
        meas(32'h4);
        chk("width", 32'h14, wid);
        wr(DE, 32'h7D0);
        meas(32'h8);
        wr(SP, 32'h9C40);
        wr(MO, 32'h1);
        meas(32'h4);
        wr(CT, 32'h0);
        wr(CT, 32'h30);
        wait (idrv === 1'b1);
        wr(CM, 32'h1);
        rd(CT, 32'h0, 32'h3F);
        rd(DU, 32'h32);
        chk("drivers", 32'h0, {30'h0, drv, idrv});
        wr(CT, 32'h30);
        wait (idrv === 1'b1);
        @(posedge pclk);
        ovr <= 1'b1;
        repeat (6) @(posedge pclk);
        chk("drivers", 32'h0, {30'h0, drv, idrv});
        rd(ST, 32'h4, 32'h4);
        ovr <= 1'b0;
        repeat (4) @(posedge pclk);
        wr(CT, 32'h30);
        wait (idrv === 1'b1);
        wr(CM, 32'h2);
        rd(CT, 32'h0, 32'h30);
        chk("drivers", 32'h0, {30'h0, drv, idrv});
        $display("test outputs done");
        stop_test();
    end
endmodule // tb_pulse_timing_parameter_engine
`default_nettype wire
